// *** rtl/lin_dominant_timeout_monitor_map.vh ***
// Register indices, field positions and reset values of the LIN monitor
`ifndef LIN_DOMINANT_TIMEOUT_MONITOR_MAP_VH
`define LIN_DOMINANT_TIMEOUT_MONITOR_MAP_VH
// Register indices; byte address is four times the index
`define IDX_TIMEOUT_CFG 16'hA0B0
`define IDX_TX_TMO_LOW 16'hA0B1
`define IDX_TX_TMO_HIGH 16'hA0B2
`define IDX_RX_TMO_LOW 16'hA0B3
`define IDX_RX_TMO_HIGH 16'hA0B4
`define IDX_CLR_WIDTH_LOW 16'hA0B5
`define IDX_CLR_WIDTH_HIGH 16'hA0B6
`define IDX_WAKE_CFG 16'hA0B7
`define IDX_ACT_WIDTH 16'hA0B8
`define IDX_IRQ_STATUS 16'hA0B9
`define IDX_IRQ_MASK 16'hA0BA
// Timeout configuration fields
`define CFG_RX_LSB 7
`define CFG_BREAK_EXIT 6
`define CFG_RX_WAKE_EN 5
`define CFG_TX_WAKE_EN 4
`define CFG_RX_FLAG 3
`define CFG_TX_FLAG 2
`define CFG_RX_IRQ_EN 1
`define CFG_TX_IRQ_EN 0
// Wakeup configuration fields
`define WKC_STUCK_FLAG 7
`define WKC_LIN_FLAG 6
`define WKC_STUCK_EN 5
`define WKC_LIN_EN 4
// Interrupt status and mask bit positions
`define IRQ_TX 0
`define IRQ_RX 1
`define IRQ_LIN 2
`define IRQ_STUCK 3
`define REG_RESET 8'h00
`endif

// *** rtl/lin_dominant_timeout_monitor.v ***
// LIN dominant timeout, bus stuck and wakeup supervisor with Wishbone slave
`include "lin_dominant_timeout_monitor_map.vh"
module lin_dominant_timeout_monitor #(
    parameter ADR_W = 18
) (
    input wire mclk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [ADR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    input wire txd_i,
    input wire rxd_i,
    input wire slow_tick_i,
    input wire in_break_i,
    output wire break_exit_o,
    output wire bus_stuck_o,
    output wire wake_o,
    output wire irq_o
);
    // Register map, one byte in the low lane of each word:
    //   timeout config      7 rx timeout bit 0, 6 break exit enable,
    //                       5 rx wake enable, 4 tx wake enable,
    //                       3 rx fault flag, 2 tx fault flag,
    //                       1 rx irq enable, 0 tx irq enable
    //   tx timeout low/high 16-bit transmit timeout value
    //   rx timeout low/high bits 8..1 and 16..9 of the receive timeout
    //   clear width low/high 16-bit stuck clear interval in slow ticks
    //   wakeup config       7 stuck flag, 6 lin wake flag,
    //                       5 stuck wake enable, 4 lin wake enable,
    //                       3..0 wakeup filter value
    //   active width        8-bit stuck active interval in slow ticks
    //   irq status          the four flags side by side, write one clears
    //   irq mask            gates each flag onto the interrupt line only
    // Flags live once, in flags_q; the config and wakeup registers show
    // them in their own positions, so software may clear from either place.
    // Timing summary, in cycles of mclk_i unless noted:
    //   tx fault    txd_i low for timeout plus one consecutive cycles
    //   rx fault    rxd_i low for 17-bit timeout plus one consecutive cycles
    //   stuck set   rxd_i low across active width plus one slow ticks
    //   stuck clear rxd_i high across clear width plus one slow ticks
    //   lin wake    rxd_i low across filter value plus one slow ticks
    // Limitations a user should know:
    //   the slow oscillator arrives as a one-cycle tick, already synchronous;
    //   a fault fires once per unbroken dominant stretch, never repeatedly;
    //   break exit is a single pulse and only while in_break_i is high;
    //   the wake output ignores the mask, since a sleeping core has no
    //   interrupt controller running to look at it.

    // Configuration storage, flags kept apart in one vector
    // Flag bits of the config and wakeup registers are never stored here,
    // which keeps a single owner for every sticky bit.
    reg [7:0] cfg_q;
    reg [7:0] tx_low_q;
    reg [7:0] tx_high_q;
    reg [7:0] rx_low_q;
    reg [7:0] rx_high_q;
    reg [7:0] clr_low_q;
    reg [7:0] clr_high_q;
    reg [7:0] wkc_q;
    reg [7:0] act_q;
    reg [3:0] mask_q;
    reg [3:0] flags_q;
    reg [3:0] flags_d;
    // Bus slave state
    // Read data is registered so the bus output comes from a flip-flop.
    reg ack_q;
    reg [31:0] dat_q;
    reg [7:0] rd_byte;
    // Monitor state
    // Each watchdog has a done bit that stops it from firing twice.
    reg [15:0] tx_cnt_q;
    reg tx_done_q;
    reg [16:0] rx_cnt_q;
    reg rx_done_q;
    reg [15:0] stk_cnt_q;
    reg stuck_q;
    reg [3:0] wk_cnt_q;
    reg wk_done_q;
    reg brk_q;
    reg wake_q;
    reg irq_q;
    wire [15:0] tx_tmo;
    wire [16:0] rx_tmo;
    wire [15:0] clr_width;
    wire [15:0] idx;
    wire tx_dom;
    wire rx_dom;
    wire tx_evt;
    wire rx_evt;
    wire stuck_evt;
    wire wk_evt;
    wire wr;
    wire [3:0] set_v;
    wire [3:0] clr_v;
    wire [3:0] en_v;

    assign tx_tmo = {tx_high_q, tx_low_q};
    assign rx_tmo = {rx_high_q, rx_low_q, cfg_q[`CFG_RX_LSB]};
    assign clr_width = {clr_high_q, clr_low_q};
    assign idx = wb_adr_i[17:2];
    // Dominant is the low level on both lines
    assign tx_dom = ~txd_i;
    assign rx_dom = ~rxd_i;

    // Write lands at the edge where the master sees ack, not earlier
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];

    // Ack one cycle after the request, dropped the cycle after
    // The slave never inserts more than this one wait state, so a master
    // that holds its request until ack sees exactly one answer per access.
    // Holding stb one cycle past ack produces a second ack a cycle later, because the
    // next value is forced low only while ack is high, so acks never come back to back.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
            dat_q <= {24'h000000, rd_byte};
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // Read mux; unmapped addresses read zero and are still acknowledged
    // Acknowledging unmapped indices keeps a stray access from hanging
    // the bus; the price is that software cannot probe for the block.
    // Flag bits are read from flags_q, not from the stored bytes.
    always @* begin
        rd_byte = 8'h00;
        if (idx == `IDX_TIMEOUT_CFG) begin
            rd_byte = {cfg_q[7:4], flags_q[`IRQ_RX], flags_q[`IRQ_TX],
                       cfg_q[1:0]};
        end else if (idx == `IDX_TX_TMO_LOW) begin
            rd_byte = tx_low_q;
        end else if (idx == `IDX_TX_TMO_HIGH) begin
            rd_byte = tx_high_q;
        end else if (idx == `IDX_RX_TMO_LOW) begin
            rd_byte = rx_low_q;
        end else if (idx == `IDX_RX_TMO_HIGH) begin
            rd_byte = rx_high_q;
        end else if (idx == `IDX_CLR_WIDTH_LOW) begin
            rd_byte = clr_low_q;
        end else if (idx == `IDX_CLR_WIDTH_HIGH) begin
            rd_byte = clr_high_q;
        end else if (idx == `IDX_WAKE_CFG) begin
            rd_byte = {flags_q[`IRQ_STUCK], flags_q[`IRQ_LIN], wkc_q[5:0]};
        end else if (idx == `IDX_ACT_WIDTH) begin
            rd_byte = act_q;
        end else if (idx == `IDX_IRQ_STATUS) begin
            rd_byte = {4'h0, flags_q};
        end else if (idx == `IDX_IRQ_MASK) begin
            rd_byte = {4'h0, mask_q};
        end
    end

    // Plain read/write storage; flag bits in it are unused
    // A write takes effect only at the edge where ack is high, which is
    // the edge at which the master samples it; an aborted cycle that
    // drops cyc before that edge leaves every register untouched.
    // Writes with the low byte lane disabled are ignored.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_q <= `REG_RESET;
            tx_low_q <= `REG_RESET;
            tx_high_q <= `REG_RESET;
            rx_low_q <= `REG_RESET;
            rx_high_q <= `REG_RESET;
            clr_low_q <= `REG_RESET;
            clr_high_q <= `REG_RESET;
            wkc_q <= `REG_RESET;
            act_q <= `REG_RESET;
            mask_q <= 4'h0;
        end else if (wr) begin
            if (idx == `IDX_TIMEOUT_CFG) begin
                cfg_q <= {wb_dat_i[7:4], 2'b00, wb_dat_i[1:0]};
            end else if (idx == `IDX_TX_TMO_LOW) begin
                tx_low_q <= wb_dat_i[7:0];
            end else if (idx == `IDX_TX_TMO_HIGH) begin
                tx_high_q <= wb_dat_i[7:0];
            end else if (idx == `IDX_RX_TMO_LOW) begin
                rx_low_q <= wb_dat_i[7:0];
            end else if (idx == `IDX_RX_TMO_HIGH) begin
                rx_high_q <= wb_dat_i[7:0];
            end else if (idx == `IDX_CLR_WIDTH_LOW) begin
                clr_low_q <= wb_dat_i[7:0];
            end else if (idx == `IDX_CLR_WIDTH_HIGH) begin
                clr_high_q <= wb_dat_i[7:0];
            end else if (idx == `IDX_WAKE_CFG) begin
                wkc_q <= {2'b00, wb_dat_i[5:0]};
            end else if (idx == `IDX_ACT_WIDTH) begin
                act_q <= wb_dat_i[7:0];
            end else if (idx == `IDX_IRQ_MASK) begin
                mask_q <= wb_dat_i[3:0];
            end
        end
    end

    // Flags clear by writing one, in their home register or in status
    // Writing zero keeps a flag, so a read-modify-write of the config
    // byte cannot lose an event that arrived between the read and write.
    // Both places share the same clear vector.
    assign clr_v[`IRQ_TX] = wr & wb_dat_i[`CFG_TX_FLAG] &
                            (idx == `IDX_TIMEOUT_CFG) |
                            wr & wb_dat_i[`IRQ_TX] & (idx == `IDX_IRQ_STATUS);
    assign clr_v[`IRQ_RX] = wr & wb_dat_i[`CFG_RX_FLAG] &
                            (idx == `IDX_TIMEOUT_CFG) |
                            wr & wb_dat_i[`IRQ_RX] & (idx == `IDX_IRQ_STATUS);
    assign clr_v[`IRQ_LIN] = wr & wb_dat_i[`WKC_LIN_FLAG] &
                             (idx == `IDX_WAKE_CFG) |
                             wr & wb_dat_i[`IRQ_LIN] &
                             (idx == `IDX_IRQ_STATUS);
    assign clr_v[`IRQ_STUCK] = wr & wb_dat_i[`WKC_STUCK_FLAG] &
                               (idx == `IDX_WAKE_CFG) |
                               wr & wb_dat_i[`IRQ_STUCK] &
                               (idx == `IDX_IRQ_STATUS);
    assign set_v = {stuck_evt, wk_evt, rx_evt, tx_evt};

    // Sticky flags; a set in the clearing cycle wins
    // Letting the set win means an event landing on the very cycle of a
    // clear is never lost; software sees the flag again and handles it.
    // The events are single-cycle pulses, so a flag cleared after the
    // event stays clear until the next stretch produces a new one.
    always @* begin
        flags_d = set_v | (flags_q & ~clr_v);
    end
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            flags_q <= 4'h0;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Transmit watchdog; fires once per unbroken dominant stretch
    // The counter holds the number of dominant cycles already seen, so the
    // event comes on the cycle that makes the count timeout plus one.
    // Any recessive cycle clears the count, so glitchy dominant bursts
    // never add up to a fault.
    // After the event the counter freezes instead of wrapping, which would
    // otherwise fire again after another full period.
    assign tx_evt = tx_dom & ~tx_done_q & (tx_cnt_q == tx_tmo);
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_cnt_q <= 16'h0000;
            tx_done_q <= 1'b0;
        end else if (!tx_dom) begin
            tx_cnt_q <= 16'h0000;
            tx_done_q <= 1'b0;
        end else if (tx_evt) begin
            tx_done_q <= 1'b1;
        end else if (!tx_done_q) begin
            tx_cnt_q <= tx_cnt_q + 16'h0001;
        end
    end

    // Receive watchdog, same scheme at 17 bits
    // Bit 0 of the timeout lives in the config byte, so software that sets
    // only the low and high bytes gets an even timeout value.
    // The event also feeds the break exit pulse below.
    // A zero timeout faults on the first dominant cycle.
    assign rx_evt = rx_dom & ~rx_done_q & (rx_cnt_q == rx_tmo);
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_cnt_q <= 17'h00000;
            rx_done_q <= 1'b0;
        end else if (!rx_dom) begin
            rx_cnt_q <= 17'h00000;
            rx_done_q <= 1'b0;
        end else if (rx_evt) begin
            rx_done_q <= 1'b1;
        end else if (!rx_done_q) begin
            rx_cnt_q <= rx_cnt_q + 17'h00001;
        end
    end

    // Stuck supervisor on slow ticks; one counter serves both directions
    // While free the counter counts dominant ticks toward the active width;
    // while stuck it counts recessive ticks toward the clear width.
    // Sharing one counter is safe because the two phases never overlap,
    // and the count restarts at each change of state.
    // An opposite level in either phase clears the count, so only one
    // uninterrupted stretch can set or clear the stuck state.
    // Only ticks are counted, never clock cycles, so the intervals keep
    // their length in slow oscillator periods whatever mclk_i runs at.
    assign stuck_evt = ~stuck_q & rx_dom & slow_tick_i &
                       (stk_cnt_q == {8'h00, act_q});
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            stk_cnt_q <= 16'h0000;
            stuck_q <= 1'b0;
        end else if (!stuck_q) begin
            if (!rx_dom) begin
                stk_cnt_q <= 16'h0000;
            end else if (stuck_evt) begin
                stk_cnt_q <= 16'h0000;
                stuck_q <= 1'b1;
            end else if (slow_tick_i) begin
                stk_cnt_q <= stk_cnt_q + 16'h0001;
            end
        end else begin
            if (rx_dom) begin
                stk_cnt_q <= 16'h0000;
            end else if (slow_tick_i && stk_cnt_q == clr_width) begin
                stk_cnt_q <= 16'h0000;
                stuck_q <= 1'b0;
            end else if (slow_tick_i) begin
                stk_cnt_q <= stk_cnt_q + 16'h0001;
            end
        end
    end

    // Wakeup filter: dominant must last filter plus one slow ticks
    // Short dominant pulses such as bit-level noise are rejected because
    // the count restarts on every recessive cycle.
    // The filter qualifies once per low stretch; a bus that stays low
    // keeps the flag set but does not re-trigger it after a clear.
    // The first tick may fall anywhere in the stretch, so the accepted
    // length is uncertain by up to one slow period.
    assign wk_evt = rx_dom & ~wk_done_q & slow_tick_i &
                    (wk_cnt_q == wkc_q[3:0]);
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wk_cnt_q <= 4'h0;
            wk_done_q <= 1'b0;
        end else if (!rx_dom) begin
            wk_cnt_q <= 4'h0;
            wk_done_q <= 1'b0;
        end else if (wk_evt) begin
            wk_done_q <= 1'b1;
        end else if (slow_tick_i && !wk_done_q) begin
            wk_cnt_q <= wk_cnt_q + 4'h1;
        end
    end

    // Per-source enables gate the interrupt path; the lin and stuck enables also gate wake
    // The mask register only affects the interrupt line.
    // Bit order follows the status register layout.
    assign en_v = {wkc_q[`WKC_STUCK_EN], wkc_q[`WKC_LIN_EN],
                   cfg_q[`CFG_RX_IRQ_EN], cfg_q[`CFG_TX_IRQ_EN]};

    // Registered outputs; wake is a level so a sleeping core can see it
    // Registering costs one cycle of lag on irq and wake, traded for
    // glitch-free outputs straight from flip-flops.
    // Break exit is built from the event itself, not the flag, so a flag
    // left set by software cannot cause a later spurious exit.
    // With the exit disabled, software must steer the break state itself.
    // The tx and rx wake sources use their own enables, independent of the irq enables.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            brk_q <= 1'b0;
            wake_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            brk_q <= rx_evt & cfg_q[`CFG_BREAK_EXIT] & in_break_i;
            wake_q <= (flags_q[`IRQ_TX] & cfg_q[`CFG_TX_WAKE_EN]) |
                      (flags_q[`IRQ_RX] & cfg_q[`CFG_RX_WAKE_EN]) |
                      (flags_q[`IRQ_LIN] & wkc_q[`WKC_LIN_EN]) |
                      (flags_q[`IRQ_STUCK] & wkc_q[`WKC_STUCK_EN]);
            irq_q <= |(flags_q & en_v & mask_q);
        end
    end
    assign break_exit_o = brk_q;
    assign bus_stuck_o = stuck_q;
    assign wake_o = wake_q;
    assign irq_o = irq_q;
endmodule // lin_dominant_timeout_monitor

// *** dv/lin_monitor_checker_asserts.sv ***
// Checker of bus handshake, break exit and bus stuck output timing
module lin_monitor_checker (
    input wire mclk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire rxd_i,
    input wire slow_tick_i,
    input wire in_break_i,
    input wire break_exit_o,
    input wire bus_stuck_o,
    input wire wake_o,
    input wire irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Request as the master holds it until the answer
    sequence s_req;
        wb_cyc_i && wb_stb_i;
    endsequence
    property p_ack_req; wb_ack_o |-> s_req; endproperty
    a_ack_req: assert property (p_ack_req) else $error("ack without request");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_rd_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("read upper bits set");
    property p_rst; $fell(rst_i) |-> !irq_o && !wake_o && !bus_stuck_o; endproperty
    a_rst: assert property (p_rst) else $error("output set after reset");
    // Break exit needs the break state and a dominant receive line
    property p_brk; break_exit_o |-> $past(in_break_i && !rxd_i); endproperty
    a_brk: assert property (p_brk) else $error("break exit uncaused");
    property p_brk_once; break_exit_o |=> !break_exit_o; endproperty
    a_brk_once: assert property (p_brk_once) else $error("break exit held");
    property p_stuck_set;
        $rose(bus_stuck_o) |-> $past(slow_tick_i && !rxd_i);
    endproperty
    a_stuck_set: assert property (p_stuck_set) else $error("stuck off tick");
    property p_stuck_clr;
        $fell(bus_stuck_o) |-> $past(slow_tick_i && rxd_i);
    endproperty
    a_stuck_clr: assert property (p_stuck_clr) else $error("clear off tick");
    property p_stuck_hold; bus_stuck_o && !rxd_i |=> bus_stuck_o; endproperty
    a_stuck_hold: assert property (p_stuck_hold) else $error("stuck lost");
endmodule // lin_monitor_checker

bind lin_dominant_timeout_monitor lin_monitor_checker chk_u (.mclk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .rxd_i, .slow_tick_i,
    .in_break_i, .break_exit_o, .bus_stuck_o, .wake_o, .irq_o);

// *** dv/lin_bus_model.sv ***
// LIN transceiver and bus model with a divided slow oscillator tick
module lin_bus_model #(
    parameter int TICK_DIV = 8
) (
    input wire mclk_i,
    input wire txd_i,
    input wire node_dom_i,
    output logic rxd_o,
    output logic slow_tick_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_q = 0;
    initial slow_tick_o = 1'b0;
    // Wired-AND bus; the pull-up keeps it recessive unless a node drives it
    assign rxd_o = txd_i & ~node_dom_i;
    // Short tick period stands in for the slow clock to keep runs brief
    always @(posedge mclk_i) begin
        cnt_q <= (cnt_q == TICK_DIV - 1) ? 0 : cnt_q + 1;
        slow_tick_o <= (cnt_q == TICK_DIV - 1);
    end
endmodule // lin_bus_model

// *** dv/lin_dominant_timeout_monitor_tb.sv ***
// Self-checking bench of the LIN dominant timeout monitor
`include "lin_dominant_timeout_monitor_map.vh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module lin_dominant_timeout_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, txd = 1, dom = 0;
    logic brk = 0;
    logic [17:0] adr = 0;
    logic [31:0] wdat = 0;
    logic [3:0] sel = 0;
    logic [7:0] d;
    logic [7:0] mdl [11];
    wire [31:0] rdat;
    wire ack, rxd, tick, bexit, stuck, wake, irq;
    int n_errors = 0, tests_run = 0, cyc_n = 0, n_brk = 0, v, t, n, a, c, f;
    always #4 mclk_i = ~mclk_i;
    lin_dominant_timeout_monitor dut_u (.mclk_i(mclk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .txd_i(txd), .rxd_i(rxd), .slow_tick_i(tick), .in_break_i(brk),
        .break_exit_o(bexit), .bus_stuck_o(stuck), .wake_o(wake), .irq_o(irq));
    lin_bus_model bus_u (.mclk_i(mclk_i), .txd_i(txd), .node_dom_i(dom),
        .rxd_o(rxd), .slow_tick_o(tick));
    // Break exit pulses seen; the timeout cuts a hang short
    always @(posedge mclk_i) begin
        if (bexit === 1'b1) n_brk++;
        cyc_n++;
        if (cyc_n == 20000) begin n_errors++; results(); end
    end
    task automatic results();
        if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One classic cycle; held until ack is sampled high
    task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] x);
        @(posedge mclk_i);
        cyc <= 1; stb <= 1; we <= w; sel <= 4'hF;
        adr <= {idx, 2'b00}; wdat <= {24'h000000, x};
        do @(posedge mclk_i); while (ack !== 1'b1);
        d = rdat[7:0];
        cyc <= 0; stb <= 0; we <= 0;
    endtask
    // Model keeps flag bits write-one-to-clear
    task automatic wr(input logic [15:0] idx, input logic [7:0] x);
        int i;
        logic [7:0] m;
        i = idx - `IDX_TIMEOUT_CFG;
        m = (i == 0) ? 8'h0C : (i == 7) ? 8'hC0 : 8'h00;
        bus(1, idx, x);
        mdl[i] = (x & ~m) | (mdl[i] & ~x & m);
    endtask
    task automatic rd(input logic [15:0] idx);
        mdl[9] = {4'h0, mdl[7][7:6], mdl[0][3:2]};
        bus(0, idx, 8'h00);
        `CHK("register", mdl[idx - `IDX_TIMEOUT_CFG], d)
    endtask
    // Dominant stretch of len sampled cycles on transmit or bus
    task automatic hold_low(input logic tx, input int len);
        @(posedge mclk_i);
        if (tx) txd <= 0; else dom <= 1;
        repeat (len) @(posedge mclk_i);
        txd <= 1; dom <= 0;
    endtask
    // Slow ticks counted while the bus is at the opposite level
    task automatic ticks(input logic lvl, output int k);
        k = 0;
        do begin
            @(posedge mclk_i);
            if (tick === 1'b1 && rxd === ~lvl) k++;
        end while (stuck !== lvl);
    endtask
    initial begin
        v = $urandom(32'hCEB2);
        foreach (mdl[i]) mdl[i] = 8'h00;
        repeat (12) @(posedge mclk_i);
        rst_i <= 0;
        for (int i = 0; i < 11; i++) rd(`IDX_TIMEOUT_CFG + i);
        bus(0, 16'h1234, 8'h00);
        `CHK("unmapped", 8'h00, d)
        for (int i = 0; i < 11; i++) begin
            wr(`IDX_TIMEOUT_CFG + i, $urandom & (i == 10 ? 15 : 255));
            rd(`IDX_TIMEOUT_CFG + i);
        end
        // Transmit timeout across both bytes; one short of it never faults
        t = 256 + $urandom_range(1, 9);
        wr(`IDX_RX_TMO_HIGH, 8'hFF); wr(`IDX_ACT_WIDTH, 8'hFF);
        wr(`IDX_TX_TMO_LOW, t[7:0]); wr(`IDX_TX_TMO_HIGH, 8'h01);
        wr(`IDX_TIMEOUT_CFG, 8'h01); wr(`IDX_IRQ_MASK, 8'h01);
        hold_low(1, t); hold_low(1, t); rd(`IDX_TIMEOUT_CFG);
        hold_low(1, t + 1); mdl[0][2] = 1; mdl[7][6] = 1;
        repeat (2) @(posedge mclk_i);
        rd(`IDX_TIMEOUT_CFG);
        `CHK("irq", 1'b1, irq)
        wr(`IDX_TIMEOUT_CFG, 8'h05); repeat (2) @(posedge mclk_i);
        `CHK("irq", 1'b0, irq)
        // Receive timeout: 17 bits, break exit on and then off
        v = $urandom_range(4, 40);
        wr(`IDX_RX_TMO_LOW, v[8:1]); wr(`IDX_RX_TMO_HIGH, 8'h00);
        wr(`IDX_TIMEOUT_CFG, {v[0], 7'h42}); brk <= 1;
        hold_low(0, v); rd(`IDX_TIMEOUT_CFG);
        hold_low(0, v + 1); mdl[0][3] = 1; repeat (3) @(posedge mclk_i);
        rd(`IDX_TIMEOUT_CFG);
        `CHK("break exits", 1, n_brk)
        wr(`IDX_TIMEOUT_CFG, {v[0], 7'h0A}); hold_low(0, v + 1); mdl[0][3] = 1;
        repeat (3) @(posedge mclk_i);
        rd(`IDX_TIMEOUT_CFG);
        `CHK("break exits", 1, n_brk)
        // Stuck and wakeup intervals count slow ticks
        a = $urandom_range(1, 6); c = $urandom_range(1, 6); f = $urandom_range(0, 15);
        wr(`IDX_ACT_WIDTH, a); wr(`IDX_CLR_WIDTH_LOW, c);
        wr(`IDX_CLR_WIDTH_HIGH, 8'h00); wr(`IDX_IRQ_MASK, 8'h08);
        wr(`IDX_WAKE_CFG, {4'hF, f[3:0]}); dom <= 1;
        ticks(1, n);
        `CHK("active ticks", a + 1, n)
        repeat (140) @(posedge mclk_i);
        mdl[7][7:6] = 2'b11; mdl[0][3] = 1;
        rd(`IDX_WAKE_CFG);
        `CHK("wake", 1'b1, wake)
        `CHK("irq", 1'b1, irq)
        rd(`IDX_IRQ_STATUS);
        dom <= 0;
        ticks(0, n);
        `CHK("clear ticks", c + 1, n)
        results();
    end
endmodule // lin_dominant_timeout_monitor_tb
